// >>> verilog/qml_cmd_core.sv
// command handling for four-wire mode switching, volatile lock bits and software reset
//
// Operation
// - four-wire wrapped burst read acts as fast read but wraps inside its window
// - wrap window size comes from the set-read-parameters setting
// - one mode at a time; only the enter opcode leaves serial mode
// - after power-up the device is in serial mode
// - enter opcode is ignored unless the quad enable bit is set
// - mode switches keep write latch, suspend state and wrap setting
// - the exit opcode returns four-wire mode to serial mode
// - lock bits protect only when lock scheme select is 1, else range bits
// - lock bits are volatile and all set after power-up and reset
// - lock opcode plus full address locks the addressed block
// - unlock opcode plus full address unlocks the addressed block
// - read-lock returns the lock byte on falling edges, msb first
// - returned byte has lsb 1 when locked, 0 when unlocked
// - global lock opcode alone sets every lock bit
// - global unlock opcode alone clears every lock bit
// - accepted reset restores defaults and signals clearing of volatile state
// - reset needs enable then reset opcode, in either mode
// - any other command after enable disarms the reset
// - reset takes about 30 us and every command is rejected meanwhile
// - four-byte address mode uses 32-bit addresses
// - wrap window defaults to eight bytes after power-up or reset
`timescale 1ns/1ns
module qml_cmd_core #(
   parameter int LOCK_LSB = qml_pkg::LOCK_LSB_DEF,
   parameter int LOCK_IDX_W = qml_pkg::LOCK_IDX_W_DEF
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io_in,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe,
   input wire logic i_quad_enable_bit,
   input wire logic i_addr4_mode,
   input wire logic i_lock_scheme_select,
   input wire logic i_range_protect_hit,
   input wire logic [31:0] i_prot_addr,
   output logic o_prot_locked,
   output logic o_four_wire_instruction_mode,
   output logic [7:0] o_read_param_bits,
   output logic o_reset_busy,
   output logic o_reset_armed,
   output logic o_sw_reset,
   input wire logic [7:0] i_burst_data,
   output logic [31:0] o_burst_addr,
   output logic o_burst_active
);
   import qml_pkg::*;

   localparam int NLOCK = 1 << LOCK_IDX_W;

   // ==========================================================
   // declarations
   qml_link_state_type st_reg;
   qml_sys_state_type sys_reg;
   logic link_rst;
   logic [5:0] cnt_reg, step, alen, dummy;
   logic [7:0] op_reg, op_in;
   logic [31:0] addr_reg, addr_in, addr_eff;
   logic op_tog_reg, addr_done_reg, over_reg, tail_reg, needs_addr;
   logic [2:0] ocnt_reg;
   logic [7:0] lock_byte;
   logic [3:0] io_out_reg, io_oe_reg;
   logic [31:0] burst_addr_reg;
   logic burst_active_reg;
   logic cs_meta_reg, cs_sync_reg, cs_prev_reg, op_seen_reg;
   logic take, clean;
   logic do_lock, do_unlock, do_lock_all, do_unlock_all;
   logic do_enter, do_exit, do_param, do_reset;
   logic qpi_reg;
   logic [7:0] param_reg;
   logic armed_reg;
   logic sw_reset_reg;
   logic [RESET_CNT_W-1:0] rcnt_reg;
   logic prot_reg;
   logic [NLOCK-1:0] lock_reg;
   logic [LOCK_IDX_W-1:0] lock_idx;

   // ==========================================================
   // helpers
   function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [1:0] ws);
      logic [5:0] m;
      logic [5:0] inc;
      m = 6'((7'd8 << ws) - 7'd1);
      inc = a[5:0] + 6'd1;
      wrap_next = {a[31:6], (a[5:0] & ~m) | (inc & m)};
   endfunction

   // ==========================================================
   // link side decode
   // mode, parameters and lock bits only change between frames, so the link reads them as
   // quasi-static values; the frame's own chip select bounds the state, count and output registers, not the captured command
   assign link_rst = i_cs_n | i_rst;
   assign step = qpi_reg ? 6'd4 : 6'd1;
   assign op_in = qpi_reg ? {op_reg[3:0], i_io_in} : {op_reg[6:0], i_io_in[0]};
   assign addr_in = qpi_reg ? {addr_reg[27:0], i_io_in} : {addr_reg[30:0], i_io_in[0]};
   assign addr_eff = i_addr4_mode ? addr_reg : {8'h00, addr_reg[23:0]};
   assign alen = (op_reg == OP_SET_PARAM) ? PARAM_BITS :
                 (i_addr4_mode ? ADDR4_BITS : ADDR3_BITS);
   assign dummy = {2'b00, param_reg[DUMMY_LSB +: 3], 1'b0} + 6'd2;
   assign lock_idx = addr_eff[LOCK_LSB +: LOCK_IDX_W];
   assign lock_byte = {7'h00, lock_reg[lock_idx]};

   always_comb begin
      needs_addr = 1'b0;
      if (sys_reg == QML_S_IDLE) begin
         case (op_in)
            OP_LOCK_ONE, OP_UNLOCK_ONE, OP_READ_LOCK: needs_addr = 1'b1;
            OP_WRAP_READ, OP_SET_PARAM: needs_addr = qpi_reg;
            default: needs_addr = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // link state machine
   always_ff @(posedge i_sclk or posedge link_rst) begin
      if (link_rst) begin
         st_reg <= QML_L_OP;
         cnt_reg <= 6'd0;
         tail_reg <= 1'b0;
      end else begin
         case (st_reg)
            QML_L_OP: begin
               if (cnt_reg + step == OP_BITS) begin
                  cnt_reg <= 6'd0;
                  st_reg <= needs_addr ? QML_L_ADDR : QML_L_DATA;
                  tail_reg <= ~needs_addr;
               end else begin
                  cnt_reg <= cnt_reg + step;
               end
            end
            QML_L_ADDR: begin
               if (cnt_reg + step == alen) begin
                  cnt_reg <= 6'd0;
                  if (op_reg == OP_WRAP_READ) begin
                     st_reg <= QML_L_DUMMY;
                  end else begin
                     st_reg <= QML_L_DATA;
                     tail_reg <= (op_reg != OP_READ_LOCK);
                  end
               end else begin
                  cnt_reg <= cnt_reg + step;
               end
            end
            QML_L_DUMMY: begin
               if (cnt_reg + 6'd1 == dummy) begin
                  cnt_reg <= 6'd0;
                  st_reg <= QML_L_DATA;
               end else begin
                  cnt_reg <= cnt_reg + 6'd1;
               end
            end
            default: st_reg <= st_reg;
         endcase
      end
   end

   // ==========================================================
   // captured command, kept after chip select rises
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         op_reg <= 8'h00;
         addr_reg <= 32'h0000_0000;
         op_tog_reg <= 1'b0;
         addr_done_reg <= 1'b0;
         over_reg <= 1'b0;
      end else begin
         if (st_reg == QML_L_OP) begin
            op_reg <= op_in;
            op_tog_reg <= op_tog_reg ^ (cnt_reg + step == OP_BITS);
            if (cnt_reg == 6'd0) begin
               addr_done_reg <= 1'b0;
               over_reg <= 1'b0;
            end
         end
         if (st_reg == QML_L_ADDR) begin
            addr_reg <= addr_in;
            addr_done_reg <= (cnt_reg + step == alen);
         end
         if (st_reg == QML_L_DATA && tail_reg) begin
            over_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // data out on falling edges
   always_ff @(negedge i_sclk or posedge link_rst) begin
      if (link_rst) begin
         io_out_reg <= 4'h0;
         io_oe_reg <= 4'h0;
         ocnt_reg <= 3'd0;
         burst_addr_reg <= 32'h0000_0000;
         burst_active_reg <= 1'b0;
      end else begin
         io_oe_reg <= 4'h0;
         case (st_reg)
            QML_L_DUMMY: begin
               burst_addr_reg <= addr_eff;
               ocnt_reg <= 3'd0;
            end
            QML_L_DATA: begin
               if (op_reg == OP_READ_LOCK && !tail_reg) begin
                  ocnt_reg <= ocnt_reg + 3'd1;
                  if (qpi_reg) begin
                     io_out_reg <= ocnt_reg[0] ? lock_byte[3:0] : lock_byte[7:4];
                     io_oe_reg <= 4'hf;
                  end else begin
                     io_out_reg <= {2'b00, lock_byte[3'd7 - ocnt_reg], 1'b0};
                     io_oe_reg <= 4'b0010;
                  end
               end else if (op_reg == OP_WRAP_READ && !tail_reg) begin
                  ocnt_reg <= ocnt_reg + 3'd1;
                  io_out_reg <= ocnt_reg[0] ? i_burst_data[3:0] : i_burst_data[7:4];
                  io_oe_reg <= 4'hf;
                  burst_active_reg <= 1'b1;
                  if (ocnt_reg[0]) begin
                     burst_addr_reg <= wrap_next(burst_addr_reg,
                                                 param_reg[WRAP_LSB +: 2]);
                  end
               end
            end
            default: io_oe_reg <= 4'h0;
         endcase
      end
   end

   // ==========================================================
   // chip select crossing into the system clock
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         op_seen_reg <= 1'b0;
      end else begin
         cs_meta_reg <= i_cs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
         op_seen_reg <= (cs_sync_reg & ~cs_prev_reg) ? op_tog_reg : op_seen_reg;
      end
   end

   // ==========================================================
   // command acceptance at frame end
   // one toggle per complete opcode, so a frame without one never replays the last command
   assign take = cs_sync_reg & ~cs_prev_reg & (op_tog_reg ^ op_seen_reg)
                 & (sys_reg == QML_S_IDLE);
   assign clean = take & ~over_reg;
   assign do_lock = clean & (op_reg == OP_LOCK_ONE) & addr_done_reg;
   assign do_unlock = clean & (op_reg == OP_UNLOCK_ONE) & addr_done_reg;
   assign do_lock_all = clean & (op_reg == OP_LOCK_ALL);
   assign do_unlock_all = clean & (op_reg == OP_UNLOCK_ALL);
   assign do_enter = clean & (op_reg == OP_ENTER_QUAD) & ~qpi_reg & i_quad_enable_bit;
   assign do_exit = clean & (op_reg == OP_EXIT_QUAD) & qpi_reg;
   assign do_param = clean & (op_reg == OP_SET_PARAM) & qpi_reg & addr_done_reg;
   assign do_reset = clean & (op_reg == OP_RESET_GO) & armed_reg;

   // ==========================================================
   // reset sequencing
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         armed_reg <= 1'b0;
      end else if (take) begin
         armed_reg <= clean & (op_reg == OP_RESET_ARM);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sys_reg <= QML_S_IDLE;
         rcnt_reg <= '0;
         sw_reset_reg <= 1'b0;
      end else begin
         sw_reset_reg <= do_reset;
         case (sys_reg)
            QML_S_IDLE: begin
               rcnt_reg <= '0;
               if (do_reset) begin
                  sys_reg <= QML_S_RESET;
               end
            end
            QML_S_RESET: begin
               rcnt_reg <= rcnt_reg + 1'b1;
               if (rcnt_reg == RESET_CNT_W'(RESET_CYCLES - 1)) begin
                  sys_reg <= QML_S_IDLE;
               end
            end
            default: sys_reg <= QML_S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // mode and read parameters
   // only the mode flag moves here; write latch, suspend and wrap live elsewhere
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         qpi_reg <= 1'b0;
      end else if (do_reset) begin
         qpi_reg <= 1'b0;
      end else if (do_enter) begin
         qpi_reg <= 1'b1;
      end else if (do_exit) begin
         qpi_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         param_reg <= RD_PARAM_RST;
      end else if (do_reset) begin
         param_reg <= RD_PARAM_RST;
      end else if (do_param) begin
         param_reg <= addr_reg[7:0];
      end
   end

   // ==========================================================
   // lock bits
   for (genvar g = 0; g < NLOCK; g++) begin : g_lock
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            lock_reg[g] <= 1'b1;
         end else if (do_reset || do_lock_all) begin
            lock_reg[g] <= 1'b1;
         end else if (do_unlock_all) begin
            lock_reg[g] <= 1'b0;
         end else if (do_lock && lock_idx == LOCK_IDX_W'(g)) begin
            lock_reg[g] <= 1'b1;
         end else if (do_unlock && lock_idx == LOCK_IDX_W'(g)) begin
            lock_reg[g] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // protection answer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prot_reg <= 1'b1;
      end else begin
         prot_reg <= i_lock_scheme_select ? lock_reg[i_prot_addr[LOCK_LSB +: LOCK_IDX_W]]
                                          : i_range_protect_hit;
      end
   end

   // ==========================================================
   // outputs
   assign o_io_out = io_out_reg;
   assign o_io_oe = io_oe_reg;
   assign o_prot_locked = prot_reg;
   assign o_four_wire_instruction_mode = qpi_reg;
   assign o_read_param_bits = param_reg;
   assign o_reset_busy = (sys_reg == QML_S_RESET);
   assign o_reset_armed = armed_reg;
   assign o_sw_reset = sw_reset_reg;
   assign o_burst_addr = burst_addr_reg;
   assign o_burst_active = burst_active_reg;
endmodule

// >>> pkg/qml_pkg.sv
// constants shared by the command handling of the serial flash mode, lock and reset group
package qml_pkg;
   // ==========================================================
   // opcodes
   localparam logic [7:0] OP_WRAP_READ = 8'h0e;
   localparam logic [7:0] OP_SET_PARAM = 8'hc0;
   localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
   localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
   localparam logic [7:0] OP_LOCK_ONE = 8'h36;
   localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
   localparam logic [7:0] OP_READ_LOCK = 8'h3d;
   localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
   localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET_GO = 8'h99;
   // ==========================================================
   // field widths and positions
   localparam logic [5:0] OP_BITS = 6'd8;
   localparam logic [5:0] ADDR3_BITS = 6'd24;
   localparam logic [5:0] ADDR4_BITS = 6'd32;
   localparam logic [5:0] PARAM_BITS = 6'd8;
   localparam int WRAP_LSB = 0;
   localparam int DUMMY_LSB = 4;
   localparam int LOCK_LSB_DEF = 16;
   localparam int LOCK_IDX_W_DEF = 11;
   // ==========================================================
   // reset values
   localparam logic [7:0] RD_PARAM_RST = 8'h10;
   // ==========================================================
   // timing
   localparam int CLK_MHZ = 50;
   localparam int RESET_TIME_NS = 30000;
   localparam int RESET_CYCLES = (RESET_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CNT_W = $clog2(RESET_CYCLES + 1);
   // ==========================================================
   // states
   typedef enum logic [1:0] {
      QML_L_OP = 2'b00,
      QML_L_ADDR = 2'b01,
      QML_L_DUMMY = 2'b11,
      QML_L_DATA = 2'b10
   } qml_link_state_type;
   typedef enum logic {
      QML_S_IDLE = 1'b0,
      QML_S_RESET = 1'b1
   } qml_sys_state_type;
endpackage

// >>> test/qml_cmd_sva.sv
// concurrent checks on the command core ports
`timescale 1ns/1ns
module qml_cmd_sva (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic [3:0] o_io_oe,
   input wire logic i_lock_scheme_select,
   input wire logic i_range_protect_hit,
   input wire logic o_prot_locked,
   input wire logic o_four_wire_instruction_mode,
   input wire logic [7:0] o_read_param_bits,
   input wire logic o_reset_busy,
   input wire logic o_sw_reset,
   input wire logic o_burst_active
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ==========
   // busy length counter and reset steps
   logic [11:0] cnt_reg;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 12'h000;
      end else begin
         cnt_reg <= o_reset_busy ? cnt_reg + 12'h001 : 12'h000;
      end
   end
   sequence s_take;
      o_sw_reset ##1 !o_sw_reset;
   endsequence
   sequence s_dflt;
      !o_four_wire_instruction_mode && o_read_param_bits == 8'h10;
   endsequence
   idle_oe_a:
      assert property (i_cs_n |-> o_io_oe == 4'h0) else $error("oe while deselected");
   oe_width_a:
      assert property (o_io_oe != 4'h0 |-> o_io_oe == (o_four_wire_instruction_mode ? 4'hf
         : 4'h2)) else $error("wrong output lines");
   take_pulse_a:
      assert property (o_sw_reset |-> s_take) else $error("reset pulse too long");
   take_dflt_a:
      assert property (o_sw_reset |=> s_dflt) else $error("defaults not restored");
   busy_len_a:
      assert property ($fell(o_reset_busy) |-> cnt_reg >= 12'h5db && cnt_reg <= 12'h5dd)
         else $error("reset window length wrong");
   busy_hold_a:
      assert property (o_reset_busy && $past(o_reset_busy, 2) |-> $stable(o_read_param_bits)
         && $stable(o_four_wire_instruction_mode)) else $error("command taken while busy");
   prot_range_a:
      assert property (!i_lock_scheme_select |=> o_prot_locked == $past(i_range_protect_hit))
         else $error("range protection not followed");
   mode_gap_a:
      assert property ($changed(o_four_wire_instruction_mode) |-> i_cs_n)
         else $error("mode changed inside a frame");
   burst_oe_a:
      assert property (o_burst_active |-> o_io_oe == 4'hf && o_four_wire_instruction_mode)
         else $error("burst data without four-wire drive");
endmodule
bind qml_cmd_core qml_cmd_sva qml_cmd_sva_inst (.i_clk, .i_rst, .i_cs_n, .o_io_oe,
   .i_lock_scheme_select, .i_range_protect_hit, .o_prot_locked,
   .o_four_wire_instruction_mode, .o_read_param_bits, .o_reset_busy, .o_sw_reset,
   .o_burst_active);

// >>> test/qml_host_model.sv
// host controller model driving the serial link
`timescale 1ns/1ns
module qml_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic [3:0] o_io,
   input wire logic [3:0] i_io
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h0;
   end
   // ==========
   // one frame: opcode, address bits, read clocks; released lines toggle
   task automatic xfer(input logic [7:0] op, input logic [31:0] ad, input int ab,
         input logic q, input int nr, output logic [63:0] rd);
      logic [39:0] sh;
      #(23 - ($time % 20));
      sh = {op, ab > 0 ? ad << (32 - ab) : 32'h0};
      rd = 64'h0;
      o_cs_n = 1'b0;
      for (int i = 0; i < 8 + ab; i += q ? 4 : 1) begin
         o_io = q ? sh[39 - i -: 4] : {~o_io[3:1], sh[39 - i]};
         #40 o_sclk = 1'b1;
         #40 o_sclk = 1'b0;
      end
      for (int i = 0; i < nr; i++) begin
         o_io = ~o_io;
         #40 o_sclk = 1'b1;
         rd = q ? {rd[59:0], i_io} : {rd[62:0], i_io[1]};
         #40 o_sclk = 1'b0;
      end
      #40 o_cs_n = 1'b1;
      o_io = ~o_io;
      #200;
   endtask
   // chip select pulse with no clocks at all
   task automatic pulse();
      #(23 - ($time % 20));
      o_cs_n = 1'b0;
      #80 o_cs_n = 1'b1;
      #200;
   endtask
endmodule

// >>> test/test_qml_cmd_core.sv
// self-checking bench for the command core
`timescale 1ns/1ns
module test_qml_cmd_core;
   import qml_pkg::*;
   // ==========
   // clock, wires, design and host
   logic clk = 1'b0, rst = 1'b1, qe = 1'b0, a4 = 1'b0, lock_scheme_select = 1'b1, hit = 1'b0, qm = 1'b0;
   logic [31:0] pa = 32'h0, ba, sa, m;
   logic [7:0] bd = 8'h0, prm, lk, pv;
   logic sclk, cs_n, lock, busy, armed, four;
   logic [3:0] hio, dout, doe, wio;
   logic [63:0] rd;
   int errors = 0;
   int num_checks = 0;
   always #10 clk = ~clk;
   assign wio = (doe & dout) | (~doe & hio);
   always @(posedge clk) bd <= ba[7:0] ^ 8'ha5;
   qml_cmd_core #(.LOCK_IDX_W(3)) qml_cmd_core_inst (.i_clk(clk), .i_rst(rst), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_io_in(wio), .o_io_out(dout), .o_io_oe(doe), .i_quad_enable_bit(qe),
      .i_addr4_mode(a4), .i_lock_scheme_select(lock_scheme_select), .i_range_protect_hit(hit),
      .i_prot_addr(pa), .o_prot_locked(lock), .o_four_wire_instruction_mode(four),
      .o_read_param_bits(prm), .o_reset_busy(busy), .o_reset_armed(armed), .o_sw_reset(),
      .i_burst_data(bd), .o_burst_addr(ba), .o_burst_active());
   qml_host_model qml_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(hio), .i_io(wio));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int ab = 0, input logic [31:0] ad = 0,
         input int nr = 0);
      qml_host_model_inst.xfer(op, ad, ab, qm, nr, rd);
   endtask
   task automatic locks();
      for (int b = 0; b < 8; b++) begin
         cmd(OP_READ_LOCK, a4 ? 32 : 24, {13'h0, 3'(b), 16'($urandom)}, qm ? 2 : 8);
         chk(rd[7:0], {7'h0, lk[b]});
      end
   endtask
   task automatic drain();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
      chk(busy, 1'b0);
   endtask
   function automatic logic [31:0] wrapexp(input logic [31:0] a, input logic [31:0] w);
      logic [31:0] e;
      e = 32'h0;
      for (int k = 0; k < 4; k++) e = {e[23:0], 8'((a & ~w) | ((a + k) & w)) ^ 8'ha5};
      return e;
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // watchdog at about five times the expected run
   initial begin
      #1_000_000;
      errors++;
      summarize();
   end
   initial begin
      void'($urandom(32'h31ae));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({four, prm, busy, armed}, {1'b0, 8'h10, 2'b00});
      lk = 8'hff;
      locks();
      $display("test defaults done");
      cmd(OP_ENTER_QUAD);
      chk(four, 1'b0);
      @(posedge clk) qe <= 1'b1;
      cmd(OP_ENTER_QUAD);
      qm = 1'b1;
      chk(four, 1'b1);
      pv = {1'b0, 3'($urandom_range(3, 0)), 2'b00, 2'($urandom)};
      cmd(OP_SET_PARAM, 8, {24'h0, pv});
      chk(prm, pv);
      m = (32'h8 << pv[1:0]) - 32'h1;
      sa = (32'($urandom) & 32'hff_ffff & ~m) | (m - 32'h1);
      cmd(OP_WRAP_READ, 24, sa, 2 * (pv[6:4] + 1) + 8);
      chk(rd[31:0], wrapexp(sa, m));
      $display("test four-wire read done");
      cmd(OP_UNLOCK_ALL);
      lk = 8'h00;
      locks();
      cmd(OP_LOCK_ALL, 0, 0, 1);
      sa = {13'h0, 3'($urandom), 16'($urandom)};
      cmd(OP_LOCK_ONE, 24, sa);
      lk[sa[18:16]] = 1'b1;
      locks();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) {lock_scheme_select, hit} <= 2'(i);
         pa <= {13'h0, 3'(sa[18:16] + (i < 4)), 16'($urandom)};
         repeat (3) @(posedge clk);
         chk(lock, lock_scheme_select ? lk[pa[18:16]] : hit);
      end
      cmd(OP_UNLOCK_ONE, 24, sa);
      lk[sa[18:16]] = 1'b0;
      locks();
      cmd(OP_EXIT_QUAD);
      qm = 1'b0;
      chk({four, prm}, {1'b0, pv});
      $display("test locks four-wire done");
      @(posedge clk) a4 <= 1'b1;
      cmd(OP_LOCK_ALL);
      lk = 8'hff;
      sa[31:24] = 8'($urandom);
      cmd(OP_UNLOCK_ONE, 32, sa);
      lk[sa[18:16]] = 1'b0;
      locks();
      @(posedge clk) a4 <= 1'b0;
      $display("test locks serial done");
      cmd(OP_RESET_ARM);
      chk(armed, 1'b1);
      cmd(OP_UNLOCK_ALL);
      chk(armed, 1'b0);
      cmd(OP_RESET_GO);
      chk(busy, 1'b0);
      cmd(OP_RESET_ARM);
      cmd(OP_RESET_GO);
      chk(busy, 1'b1);
      cmd(OP_UNLOCK_ALL);
      drain();
      qml_host_model_inst.pulse();
      lk = 8'hff;
      locks();
      $display("test reset serial done");
      cmd(OP_ENTER_QUAD);
      qm = 1'b1;
      cmd(OP_SET_PARAM, 8, 32'h32);
      cmd(OP_RESET_ARM);
      cmd(OP_RESET_GO);
      drain();
      qm = 1'b0;
      chk({four, prm}, {1'b0, 8'h10});
      $display("test reset four-wire done");
      summarize();
   end
endmodule
